// >>> src/adce_engine.sv
// Drive-side ATA command engine with task file, sector reads and feature state.
`timescale 1ns/1ps
module adce_engine #(
  parameter logic [27:0] CAPACITY = adce_pkg::CAPACITY_RST
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  output logic intrq,
  output logic dmarq,
  input wire logic dma_rd,
  output logic [15:0] dma_data,
  output logic media_req,
  output logic [27:0] media_lba,
  input wire adce_pkg::adce_media_type media,
  input wire logic [4:0] protect_flags,
  output logic [7:0] xfer_mode,
  output logic look_ahead,
  output logic keep_settings,
  output logic long_extra4,
  output logic idle_mode,
  output logic sec_frozen
);
  adce_pkg::adce_state_type state;
  adce_pkg::adce_tf_type tf;
  adce_pkg::adce_class_type cur_cl;
  logic [7:0] err_reg;
  logic bsy;
  logic drq;
  logic err_bit;
  logic [8:0] remain;
  logic [7:0] rd_ptr;
  logic [7:0] wr_ptr;
  logic [7:0] spt;
  logic [4:0] heads;
  logic [7:0] mult;
  logic [15:0] buf_q;

  function automatic adce_pkg::adce_class_type cmd_class(input logic [7:0] op);
    adce_pkg::adce_class_type c;
    c = adce_pkg::CL_BAD;
    case (op)
      8'h20, 8'h21, 8'h24, 8'hC4, 8'h29: c = adce_pkg::CL_PIO;
      8'h40, 8'h42: c = adce_pkg::CL_VFY;
      8'hC8, 8'hC9, 8'h25: c = adce_pkg::CL_DMA;
      8'hE4: c = adce_pkg::CL_RBUF;
      8'h97, 8'hE3, 8'h95, 8'hE1: c = adce_pkg::CL_IDLE;
      8'hDE, 8'hDF: c = adce_pkg::CL_NOP;
      8'h91: c = adce_pkg::CL_INITP;
      8'hC6: c = adce_pkg::CL_SETMULT;
      8'hEF: c = adce_pkg::CL_SETF;
      8'hF1, 8'hF2, 8'hF3, 8'hF4, 8'hF6: c = adce_pkg::CL_SEC;
      8'hF5: c = adce_pkg::CL_FREEZE;
      default: begin
        if (op[7:4] == 4'h1) begin
          c = adce_pkg::CL_NOP;
        end else if (op[7:4] == 4'h7) begin
          c = adce_pkg::CL_SEEK;
        end
      end
    endcase
    return c;
  endfunction : cmd_class

  // Linear address of the task file, in LBA or cylinder/head/sector form.
  function automatic logic [31:0] tf_lba(input adce_pkg::adce_tf_type t,
                                         input logic [7:0] s, input logic [4:0] h);
    logic [31:0] x;
    x = 32'h0000_0000;
    if (t.dh[adce_pkg::DH_LBA]) begin
      x = {4'h0, t.dh[3:0], t.cyl_hi, t.cyl_lo, t.sector};
    end else begin
      x = ({16'h0000, t.cyl_hi, t.cyl_lo} * {27'h000_0000, h} + {28'h000_0000, t.dh[3:0]});
      x = x * {24'h00_0000, s} + {24'h00_0000, t.sector} - 32'h0000_0001;
    end
    return x;
  endfunction : tf_lba

  function automatic adce_pkg::adce_tf_type next_tf(input adce_pkg::adce_tf_type t,
                                                    input logic [7:0] s, input logic [4:0] h);
    adce_pkg::adce_tf_type n;
    logic [27:0] l;
    logic [15:0] cyl;
    n = t;
    l = {t.dh[3:0], t.cyl_hi, t.cyl_lo, t.sector} + 28'h000_0001;
    cyl = {t.cyl_hi, t.cyl_lo} + 16'h0001;
    if (t.dh[adce_pkg::DH_LBA]) begin
      {n.dh[3:0], n.cyl_hi, n.cyl_lo, n.sector} = l;
    end else if (t.sector < s) begin
      n.sector = t.sector + 8'h01;
    end else begin
      n.sector = 8'h01;
      if ({1'b0, t.dh[3:0]} + 5'h01 < h) begin
        n.dh[3:0] = t.dh[3:0] + 4'h1;
      end else begin
        n.dh[3:0] = 4'h0;
        {n.cyl_hi, n.cyl_lo} = cyl;
      end
    end
    return n;
  endfunction : next_tf

  wire buf_we = state == adce_pkg::ST_WAIT && media.valid;
  wire host_wr = wr && !bsy && !drq;
  wire cmd_wr = host_wr && addr == adce_pkg::A_CMD;
  wire srst = wr && addr == adce_pkg::A_CTRL && wdata[adce_pkg::CTRL_SRST];
  wire adce_pkg::adce_class_type new_cl = cmd_class(wdata[7:0]);
  wire [31:0] cur_lba = tf_lba(tf, spt, heads);
  wire [8:0] req_count = (tf.count == 8'h00) ? adce_pkg::FULL_COUNT : {1'b0, tf.count}; // [RL1]
  wire is_read = new_cl == adce_pkg::CL_PIO || new_cl == adce_pkg::CL_VFY ||
                 new_cl == adce_pkg::CL_DMA;

  wire sf_known = tf.features == 8'h02 || tf.features == 8'h82 ||
                  tf.features == adce_pkg::SF_XFER || tf.features == adce_pkg::SF_LA_OFF ||
                  tf.features == adce_pkg::SF_LA_ON || tf.features == adce_pkg::SF_POR_OFF ||
                  tf.features == adce_pkg::SF_POR_ON || tf.features == 8'h69 ||
                  tf.features == 8'h96 || tf.features == 8'h97 ||
                  tf.features == adce_pkg::SF_LONG4 || tf.features == 8'h05 ||
                  tf.features == 8'h85 || tf.features == 8'h09 || tf.features == 8'h89 ||
                  tf.features == 8'h0A || tf.features == 8'h8A; // [RL20]
  wire chs_bad = !tf.dh[adce_pkg::DH_LBA] &&
                 (tf.sector == 8'h00 || tf.sector > spt || {1'b0, tf.dh[3:0]} >= heads);
  wire range_bad = chs_bad || cur_lba >= {4'h0, CAPACITY};
  wire sec_cl = new_cl == adce_pkg::CL_SEC || new_cl == adce_pkg::CL_FREEZE;
  wire imm_abort = new_cl == adce_pkg::CL_BAD || // [RL24]
                   (new_cl == adce_pkg::CL_SETF && !sf_known) ||
                   (sec_cl && sec_frozen) || // [RL17]
                   (new_cl == adce_pkg::CL_SETMULT && tf.count > adce_pkg::MAX_MULT); // [RL23]
  wire seek_bad = new_cl == adce_pkg::CL_SEEK && range_bad; // [RL15]
  wire imm_ok = cmd_wr && !is_read && new_cl != adce_pkg::CL_RBUF && !imm_abort && !seek_bad;
  wire setf_ok = imm_ok && new_cl == adce_pkg::CL_SETF;

  wire last = remain == 9'h001;
  wire cur_vfy = cur_cl == adce_pkg::CL_VFY;
  wire cur_dma = cur_cl == adce_pkg::CL_DMA;
  wire cur_rbuf = cur_cl == adce_pkg::CL_RBUF;
  wire media_done = state == adce_pkg::ST_WAIT && media.done;
  wire media_ok = media_done && !media.err;
  wire media_bad = media_done && media.err;
  wire pio_take = rd && addr == adce_pkg::A_DATA && drq && !cur_dma;
  wire dma_take = dma_rd && dmarq;
  wire word_take = state == adce_pkg::ST_XFER && (pio_take || dma_take);
  wire sector_taken = word_take && rd_ptr == adce_pkg::LAST_WORD; // [RL4]
  wire vfy_done = media_ok && cur_vfy && last;
  wire advance = (media_ok && cur_vfy && !last) || (sector_taken && !last && !cur_rbuf);
  wire xfer_end = sector_taken && (last || cur_rbuf);

  wire intr_set = imm_ok || (cmd_wr && (imm_abort || seek_bad)) ||
                  (cmd_wr && new_cl == adce_pkg::CL_RBUF) || // [RL13]
                  (media_ok && !cur_vfy && !cur_dma) || // [RL3] [RL8]
                  vfy_done || media_bad || (xfer_end && cur_dma); // [RL6] [RL9]
  wire intr_clr = (rd && addr == adce_pkg::A_CMD) || cmd_wr;

  wire [7:0] status = {bsy, 1'b1, 1'b0, 1'b1, drq, 2'b00, err_bit};
  wire [15:0] prot_word = {protect_flags[4:2], 3'b000, protect_flags[1:0], 8'h00}; // [RL22]
  wire [15:0] rd_mux = (addr == adce_pkg::A_DATA) ? buf_q :
                       (addr == adce_pkg::A_FEAT) ? {8'h00, err_reg} :
                       (addr == adce_pkg::A_COUNT) ? {8'h00, tf.count} :
                       (addr == adce_pkg::A_SECTOR) ? {8'h00, tf.sector} :
                       (addr == adce_pkg::A_CYL_LO) ? {8'h00, tf.cyl_lo} :
                       (addr == adce_pkg::A_CYL_HI) ? {8'h00, tf.cyl_hi} :
                       (addr == adce_pkg::A_DH) ? {8'h00, tf.dh} :
                       (addr == adce_pkg::A_CMD) ? {8'h00, status} :
                       (addr == adce_pkg::A_PROT) ? prot_word : 16'h0000;

  adce_sec_buf u_buf (
    .mclk(mclk),
    .we(buf_we),
    .waddr(wr_ptr),
    .wdata(media.data),
    .raddr(rd_ptr),
    .rdata(buf_q)
  );

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 16'h0000;
      dma_data <= 16'h0000;
    end else begin
      rdata <= rd ? rd_mux : 16'h0000;
      dma_data <= dma_take ? buf_q : dma_data;
    end
  end

  // A set in the cycle of a status read wins, so no interrupt is lost.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      intrq <= 1'b0;
    end else if (intr_set) begin
      intrq <= 1'b1;
    end else if (intr_clr || srst) begin
      intrq <= 1'b0;
    end
  end

  // Task file: the engine writes it while busy or during a data transfer, the host only while neither busy nor DRQ is set.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tf <= '0;
    end else if (advance) begin
      tf <= next_tf(tf, spt, heads);
    end else if (media_bad) begin
      tf.count <= remain[7:0]; // [RL7]
    end else if (vfy_done || xfer_end) begin
      tf.count <= 8'h00;
    end else if (host_wr) begin
      case (addr)
        adce_pkg::A_FEAT: tf.features <= wdata[7:0];
        adce_pkg::A_COUNT: tf.count <= wdata[7:0];
        adce_pkg::A_SECTOR: tf.sector <= wdata[7:0];
        adce_pkg::A_CYL_LO: tf.cyl_lo <= wdata[7:0];
        adce_pkg::A_CYL_HI: tf.cyl_hi <= wdata[7:0];
        adce_pkg::A_DH: tf.dh <= wdata[7:0];
        default: tf <= tf;
      endcase
    end
  end

  // Feature, geometry and power state.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      xfer_mode <= adce_pkg::XFER_MODE_RST;
      look_ahead <= adce_pkg::LOOKAHEAD_RST;
      keep_settings <= 1'b0;
      long_extra4 <= 1'b0;
      idle_mode <= 1'b0;
      sec_frozen <= 1'b0;
      spt <= adce_pkg::SPT_RST;
      heads <= adce_pkg::HEADS_RST;
      mult <= adce_pkg::MAX_MULT;
    end else if (srst && !keep_settings) begin
      xfer_mode <= adce_pkg::XFER_MODE_RST; // [RL19]
      look_ahead <= adce_pkg::LOOKAHEAD_RST;
      long_extra4 <= 1'b0;
    end else if (setf_ok) begin
      case (tf.features)
        adce_pkg::SF_XFER: xfer_mode <= tf.count; // [RL18]
        adce_pkg::SF_LA_OFF: look_ahead <= 1'b0; // [RL18]
        adce_pkg::SF_LA_ON: look_ahead <= 1'b1; // [RL18]
        adce_pkg::SF_POR_OFF: keep_settings <= 1'b1; // [RL19]
        adce_pkg::SF_POR_ON: keep_settings <= 1'b0; // [RL19]
        adce_pkg::SF_LONG4: long_extra4 <= 1'b1; // [RL21]
        default: keep_settings <= keep_settings; // [RL20]
      endcase
    end else if (imm_ok) begin
      case (new_cl)
        adce_pkg::CL_IDLE: idle_mode <= 1'b1; // [RL11]
        adce_pkg::CL_INITP: begin
          idle_mode <= 1'b1; // [RL10]
          spt <= tf.count;
          heads <= {1'b0, tf.dh[3:0]} + 5'h01;
        end
        adce_pkg::CL_SETMULT: mult <= tf.count; // [RL23]
        adce_pkg::CL_FREEZE: sec_frozen <= 1'b1; // [RL17]
        default: idle_mode <= idle_mode; // [RL12] [RL14] [RL16]
      endcase
    end
  end

  // Sector sequencer. With the block size held at one, a multiple read
  // interrupts on every sector, exactly like a plain PIO read.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= adce_pkg::ST_IDLE;
      cur_cl <= adce_pkg::CL_NOP;
      bsy <= 1'b0;
      drq <= 1'b0;
      dmarq <= 1'b0;
      err_bit <= 1'b0;
      err_reg <= adce_pkg::ERR_NONE;
      remain <= 9'h000;
      rd_ptr <= 8'h00;
      wr_ptr <= 8'h00;
      media_req <= 1'b0;
      media_lba <= 28'h000_0000;
    end else if (srst) begin
      state <= adce_pkg::ST_IDLE;
      bsy <= 1'b0;
      drq <= 1'b0;
      dmarq <= 1'b0;
      media_req <= 1'b0;
    end else begin
      media_req <= 1'b0;
      case (state)
        adce_pkg::ST_IDLE: begin
          if (cmd_wr) begin
            cur_cl <= new_cl;
            err_bit <= imm_abort || seek_bad;
            err_reg <= imm_abort ? adce_pkg::ERR_ABRT : // [RL24]
                       seek_bad ? adce_pkg::ERR_IDNF : adce_pkg::ERR_NONE; // [RL15]
            rd_ptr <= 8'h00;
            if (is_read) begin
              bsy <= 1'b1; // [RL5]
              remain <= req_count; // [RL1]
              state <= adce_pkg::ST_FETCH;
            end else if (new_cl == adce_pkg::CL_RBUF) begin
              remain <= 9'h001;
              drq <= 1'b1; // [RL13]
              state <= adce_pkg::ST_XFER;
            end
          end
        end
        adce_pkg::ST_FETCH: begin
          media_req <= 1'b1;
          media_lba <= cur_lba[27:0]; // [RL2]
          wr_ptr <= 8'h00;
          state <= adce_pkg::ST_WAIT;
        end
        adce_pkg::ST_WAIT: begin
          if (media.valid) begin
            wr_ptr <= wr_ptr + 8'h01;
          end
          if (media_bad) begin
            bsy <= 1'b0; // [RL7]
            err_bit <= 1'b1;
            err_reg <= adce_pkg::ERR_UNC;
            state <= adce_pkg::ST_IDLE;
          end else if (media_ok && cur_vfy) begin
            remain <= remain - 9'h001; // [RL5]
            bsy <= !last; // [RL6]
            state <= last ? adce_pkg::ST_IDLE : adce_pkg::ST_FETCH;
          end else if (media_ok) begin
            bsy <= 1'b0; // [RL3]
            drq <= 1'b1;
            dmarq <= cur_dma; // [RL9]
            rd_ptr <= 8'h00;
            state <= adce_pkg::ST_XFER;
          end
        end
        adce_pkg::ST_XFER: begin
          if (word_take) begin
            rd_ptr <= rd_ptr + 8'h01;
          end
          if (sector_taken) begin
            drq <= 1'b0; // [RL4]
            dmarq <= 1'b0;
            remain <= remain - 9'h001;
            bsy <= !xfer_end; // [RL3]
            state <= xfer_end ? adce_pkg::ST_IDLE : adce_pkg::ST_FETCH;
          end
        end
        default: state <= adce_pkg::ST_IDLE;
      endcase
    end
  end
endmodule : adce_engine

// >>> pkg/adce_pkg.sv
// Constants, types and the rule summary for the drive-side command engine.
// Contract
// RL1 - Sector reads move 1 to 256 sectors; a count of zero means 256.
// RL2 - A sector read starts at the address held in the task file at issue.
// RL3 - PIO read: busy, load sector, set DRQ, clear busy, interrupt, per sector.
// RL4 - Host takes the whole 512-byte sector before the next one is prepared.
// RL5 - Read-verify acts like a read but never sets DRQ; busy on acceptance.
// RL6 - Verify success clears busy, interrupts, leaves last verified address.
// RL7 - Verify error stops at failing sector, loads remaining count into count.
// RL8 - Multiple reads interrupt once per block of the set-multiple size.
// RL9 - DMA reads move the counted sectors with DMA-mode transfers.
// RL10 - Initialize parameters: busy, idle, interrupt; sets sectors and heads. The engine completes it without ever setting busy.
// RL11 - Any of the idle opcodes puts the drive into idle mode.
// RL12 - Media lock and unlock complete as no-operations.
// RL13 - Read buffer returns present buffer contents with single-sector PIO handshake.
// RL14 - Any opcode with upper nibble one completes as a no-operation.
// RL15 - Seek only range-checks the address and reports an error if out of range.
// RL16 - The security opcodes are decoded and accepted.
// RL17 - After freeze lock, security commands are rejected until hardware reset.
// RL18 - Feature 03H sets transfer mode; 55H and AAH disable and enable look-ahead.
// RL19 - Features 66H and CCH stop and restore default reload at soft reset.
// RL20 - Write-cache features and 69H, 96H, 97H are accepted without effect.
// RL21 - Feature BBH makes long commands carry four extra bytes.
// RL22 - Protection word reports bits 15, 14, 13, 9 and 8 as protection flags.
// RL23 - Set-multiple block count is limited to at most one sector.
// RL24 - Undecoded opcodes or features abort through error, status and interrupt.
package adce_pkg;
  localparam logic [3:0] A_DATA = 4'h0;
  localparam logic [3:0] A_FEAT = 4'h1;
  localparam logic [3:0] A_COUNT = 4'h2;
  localparam logic [3:0] A_SECTOR = 4'h3;
  localparam logic [3:0] A_CYL_LO = 4'h4;
  localparam logic [3:0] A_CYL_HI = 4'h5;
  localparam logic [3:0] A_DH = 4'h6;
  localparam logic [3:0] A_CMD = 4'h7;
  localparam logic [3:0] A_PROT = 4'h8;
  localparam logic [3:0] A_CTRL = 4'h9;

  localparam int DH_LBA = 6;
  localparam int CTRL_SRST = 2;

  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_ABRT = 8'h04;
  localparam logic [7:0] ERR_IDNF = 8'h10;
  localparam logic [7:0] ERR_UNC = 8'h40;

  localparam logic [8:0] FULL_COUNT = 9'h100;
  localparam logic [7:0] LAST_WORD = 8'hFF;
  localparam logic [7:0] MAX_MULT = 8'h01;

  localparam logic [7:0] XFER_MODE_RST = 8'h00;
  localparam logic LOOKAHEAD_RST = 1'b1;
  localparam logic [7:0] SPT_RST = 8'h3F;
  localparam logic [4:0] HEADS_RST = 5'h10;
  localparam logic [27:0] CAPACITY_RST = 28'h010_0000;

  localparam logic [7:0] SF_XFER = 8'h03;
  localparam logic [7:0] SF_LA_OFF = 8'h55;
  localparam logic [7:0] SF_LA_ON = 8'hAA;
  localparam logic [7:0] SF_POR_OFF = 8'h66;
  localparam logic [7:0] SF_POR_ON = 8'hCC;
  localparam logic [7:0] SF_LONG4 = 8'hBB;

  typedef struct packed {
    logic [7:0] features;
    logic [7:0] count;
    logic [7:0] sector;
    logic [7:0] cyl_lo;
    logic [7:0] cyl_hi;
    logic [7:0] dh;
  } adce_tf_type;

  typedef struct packed {
    logic valid;
    logic [15:0] data;
    logic done;
    logic err;
  } adce_media_type;

  typedef enum logic [3:0] {
    CL_PIO, CL_VFY, CL_DMA, CL_RBUF, CL_IDLE, CL_NOP, CL_SEEK, CL_INITP,
    CL_SETMULT, CL_SETF, CL_SEC, CL_FREEZE, CL_BAD
  } adce_class_type;

  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_WAIT, ST_XFER} adce_state_type;
endpackage : adce_pkg

// >>> src/adce_sec_buf.sv
// One-sector data buffer, written by the media side and read by the host side.
`timescale 1ns/1ps
module adce_sec_buf (
  input wire logic mclk,
  input wire logic we,
  input wire logic [7:0] waddr,
  input wire logic [15:0] wdata,
  input wire logic [7:0] raddr,
  output logic [15:0] rdata
);
  logic [15:0] mem [0:255];

  // Contents are not cleared at reset; a buffer read returns whatever is present.
  always_ff @(posedge mclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  assign rdata = mem[raddr];
endmodule : adce_sec_buf

// >>> tb/adce_media_model.sv
// Media-side model: 256 words and a done pulse per sector request.
`timescale 1ns/1ps
module adce_media_model (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic media_req,
  input wire logic [27:0] media_lba,
  input wire logic [27:0] err_lba,
  input wire logic slow,
  output adce_pkg::adce_media_type media
);
  logic [27:0] lba;
  logic [8:0] idx;
  logic run, tick;
  // Idle data toggles so that a word taken outside valid never looks right.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      media <= '0;
      lba <= '0;
      idx <= '0;
      run <= 1'b0;
      tick <= 1'b0;
    end else begin
      media.valid <= 1'b0;
      media.done <= 1'b0;
      media.err <= 1'b0;
      media.data <= ~media.data;
      tick <= ~tick;
      if (media_req) begin
        lba <= media_lba;
        idx <= '0;
        run <= 1'b1;
      end else if (run && (!slow || tick)) begin
        if (idx == 9'h100) begin
          media.done <= 1'b1;
          media.err <= (lba == err_lba);
          run <= 1'b0;
        end else begin
          media.valid <= 1'b1;
          media.data <= {lba[7:0], idx[7:0]};
          idx <= idx + 9'h001;
        end
      end
    end
  end
endmodule : adce_media_model

// >>> tb/adce_engine_assertions.sv
// Concurrent checks on the command engine ports.
`timescale 1ns/1ps
module adce_engine_checker (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [15:0] rdata,
  input wire logic intrq,
  input wire logic dmarq,
  input wire logic dma_rd,
  input wire logic media_req,
  input wire adce_pkg::adce_media_type media,
  input wire logic [4:0] protect_flags,
  input wire logic [7:0] xfer_mode,
  input wire logic look_ahead,
  input wire logic idle_mode,
  input wire logic sec_frozen
);
  wire cmd_wr = wr && addr == adce_pkg::A_CMD;
  wire srst_wr = wr && addr == adce_pkg::A_CTRL && wdata[adce_pkg::CTRL_SRST];
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  prot_word_a: assert property (rd && addr == adce_pkg::A_PROT |=>
    rdata == {$past(protect_flags[4:2]), 3'b000, $past(protect_flags[1:0]), 8'h00})
    else $error("protection word wrong");
  media_pulse_a: assert property (media_req |=> !media_req)
    else $error("media request too long");
  error_int_a: assert property (media.done && media.err |=> intrq)
    else $error("no error interrupt");
  dma_hold_a: assert property ($fell(dmarq) |-> $past(dma_rd) || $past(srst_wr))
    else $error("dma request dropped early");
  dma_quiet_a: assert property ($rose(dmarq) |-> !intrq)
    else $error("interrupt on dma sector");
  idle_set_a: assert property (cmd_wr && wdata[7:0] inside {8'h97, 8'he3, 8'h95, 8'he1}
    |=> idle_mode) else $error("idle not entered");
  freeze_keep_a: assert property (sec_frozen |=> sec_frozen)
    else $error("freeze lost");
  mode_cause_a: assert property ($changed(xfer_mode) |-> $past(wr))
    else $error("mode changed unbidden");
  look_cause_a: assert property ($changed(look_ahead) |-> $past(wr))
    else $error("look-ahead changed unbidden");
  cover property (media.done && media.err);
  cover property ($rose(dmarq));
  cover property ($rose(sec_frozen));
endmodule : adce_engine_checker

bind adce_engine adce_engine_checker u_chk (.mclk, .rst_n, .addr, .wdata, .wr, .rd, .rdata,
  .intrq, .dmarq, .dma_rd, .media_req, .media, .protect_flags, .xfer_mode, .look_ahead,
  .idle_mode, .sec_frozen);

// >>> tb/adce_engine_bench.sv
// Self-checking bench for the drive-side command engine.
`timescale 1ns/1ps
module adce_engine_bench;
  logic mclk, rst_n, wr, rd, dma_rd, slow, media_req, intrq, dmarq;
  logic look_ahead, keep_settings, long_extra4, idle_mode, sec_frozen;
  logic [3:0] addr;
  logic [4:0] protect_flags;
  logic [7:0] xfer_mode;
  logic [15:0] wdata, rdata, dma_data, v;
  logic [27:0] media_lba, err_lba;
  adce_pkg::adce_media_type media;
  int errors, total_checks;
  logic [7:0] pio_ops[5] = '{8'h20, 8'h21, 8'h24, 8'hc4, 8'h29};
  adce_engine #(.CAPACITY(28'h000_0100)) dut (.mclk(mclk), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .intrq(intrq), .dmarq(dmarq),
    .dma_rd(dma_rd), .dma_data(dma_data), .media_req(media_req), .media_lba(media_lba),
    .media(media), .protect_flags(protect_flags), .xfer_mode(xfer_mode),
    .look_ahead(look_ahead), .keep_settings(keep_settings), .long_extra4(long_extra4),
    .idle_mode(idle_mode), .sec_frozen(sec_frozen));
  adce_media_model media_model (.mclk(mclk), .rst_n(rst_n), .media_req(media_req),
    .media_lba(media_lba), .err_lba(err_lba), .slow(slow), .media(media));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic check(input string name, input logic [15:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic wreg(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [3:0] a);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : rreg
  task automatic wait_int(input bit dma = 1'b0);
    int n;
    n = 0;
    #1;
    while ((dma ? dmarq : intrq) !== 1'b1 && n < 4000) begin
      @(posedge mclk);
      #1 n++;
    end
    check(dma ? "dmarq" : "intrq", 16'(dma ? dmarq : intrq), 16'h0001);
  endtask : wait_int
  task automatic tf(input logic [7:0] c, s, cl, dh);
    wreg(adce_pkg::A_COUNT, {8'h00, c});
    wreg(adce_pkg::A_SECTOR, {8'h00, s});
    wreg(adce_pkg::A_CYL_LO, {8'h00, cl});
    wreg(adce_pkg::A_CYL_HI, 16'h0000);
    wreg(adce_pkg::A_DH, {8'h00, dh});
  endtask : tf
  task automatic issue(input logic [7:0] op, er);
    wreg(adce_pkg::A_CMD, {8'h00, op});
    wait_int();
    rreg(adce_pkg::A_FEAT);
    check("error", v, {8'h00, er});
    rreg(adce_pkg::A_CMD);
    check("status err", 16'(v[0]), 16'(er != 8'h00));
  endtask : issue
  task automatic feat(input logic [7:0] f, c, er);
    wreg(adce_pkg::A_FEAT, {8'h00, f});
    wreg(adce_pkg::A_COUNT, {8'h00, c});
    issue(8'hef, er);
  endtask : feat
  task automatic read_sector(input logic [7:0] hi);
    wait_int();
    rreg(adce_pkg::A_CMD);
    check("bsy drq", 16'({v[7], v[3]}), 16'h0001);
    for (int w = 0; w < 256; w++) begin
      rreg(adce_pkg::A_DATA);
      if (w == 0 || w == 255) check("word", v, {hi, 8'(w)});
    end
  endtask : read_sector
  task automatic t_pio(input logic [7:0] op);
    tf(8'h02, 8'h05, 8'h00, 8'h40);
    wreg(adce_pkg::A_CMD, {8'h00, op});
    read_sector(8'h05);
    read_sector(8'h06);
    rreg(adce_pkg::A_COUNT);
    check("count", v, 16'h0000);
    check("last int", 16'(intrq), 16'h0000);
    $display("pio read %h finished", op);
  endtask : t_pio
  task automatic t_dma(input logic [7:0] op);
    tf(8'h01, 8'h30, 8'h00, 8'h40);
    wreg(adce_pkg::A_CMD, {8'h00, op});
    wait_int(1'b1);
    for (int w = 0; w < 256; w++) begin
      @(posedge mclk);
      dma_rd <= 1'b1;
      @(posedge mclk);
      dma_rd <= 1'b0;
      #1 if (w == 0 || w == 255) check("dma word", dma_data, {8'h30, 8'(w)});
    end
    wait_int();
    rreg(adce_pkg::A_CMD);
    wreg(adce_pkg::A_CMD, 16'h00e4);
    read_sector(8'h30);
    $display("dma read %h finished", op);
  endtask : t_dma
  task automatic t_verify;
    slow = 1'b1;
    err_lba = 28'h000_0013;
    tf(8'h00, 8'h10, 8'h00, 8'h40);
    wreg(adce_pkg::A_CMD, 16'h0040);
    rreg(adce_pkg::A_CMD);
    check("vfy bsy", 16'(v[7]), 16'h0001);
    wait_int();
    rreg(adce_pkg::A_FEAT);
    check("vfy error", v, {8'h00, adce_pkg::ERR_UNC});
    rreg(adce_pkg::A_COUNT);
    check("vfy left", v, 16'h00fd);
    rreg(adce_pkg::A_SECTOR);
    check("vfy fail at", v, 16'h0013);
    slow = 1'b0;
    tf(8'h03, 8'h20, 8'h00, 8'h40);
    issue(8'h42, 8'h00);
    check("vfy drq", 16'({v[7], v[3]}), 16'h0000);
    rreg(adce_pkg::A_SECTOR);
    check("vfy last", v, 16'h0022);
    $display("verify finished");
  endtask : t_verify
  task automatic t_cmds;
    logic [7:0] ops[11] = '{8'hde, 8'hdf, 8'h10, 8'h1f, 8'h97, 8'he3, 8'h95, 8'he1, 8'hf1,
                            8'hf3, 8'hf4};
    check("idle off", 16'(idle_mode), 16'h0000);
    foreach (ops[i]) issue(ops[i], 8'h00);
    check("idle on", 16'(idle_mode), 16'h0001);
    tf(8'h20, 8'h20, 8'h00, 8'h03);
    issue(8'h91, 8'h00);
    issue(8'h7a, 8'h00);
    tf(8'h20, 8'h21, 8'h00, 8'h03);
    issue(8'h70, adce_pkg::ERR_IDNF);
    tf(8'h20, 8'h01, 8'h00, 8'h04);
    issue(8'h70, adce_pkg::ERR_IDNF);
    tf(8'h01, 8'h00, 8'h01, 8'h40);
    issue(8'h70, adce_pkg::ERR_IDNF);
    tf(8'h02, 8'hff, 8'h00, 8'h40);
    issue(8'h70, 8'h00);
    issue(8'hc6, adce_pkg::ERR_ABRT);
    issue(8'h00, adce_pkg::ERR_ABRT);
    issue(8'hf6, 8'h00);
    issue(8'hf5, 8'h00);
    issue(8'hf2, adce_pkg::ERR_ABRT);
    $display("commands finished");
  endtask : t_cmds
  task automatic t_feat;
    logic [7:0] nops[5] = '{8'h02, 8'h82, 8'h69, 8'h96, 8'h97};
    feat(adce_pkg::SF_XFER, 8'h0c, 8'h00);
    feat(adce_pkg::SF_LA_OFF, 8'h00, 8'h00);
    feat(adce_pkg::SF_LONG4, 8'h00, 8'h00);
    foreach (nops[i]) feat(nops[i], 8'h00, 8'h00);
    feat(8'h12, 8'h00, adce_pkg::ERR_ABRT);
    check("mode", 16'({xfer_mode, look_ahead, long_extra4}), 16'h0031);
    wreg(adce_pkg::A_CTRL, 16'h0004);
    wreg(adce_pkg::A_CTRL, 16'h0000);
    check("defaults", 16'({xfer_mode, look_ahead, long_extra4}), 16'h0002);
    feat(adce_pkg::SF_POR_OFF, 8'h00, 8'h00);
    feat(adce_pkg::SF_XFER, 8'h22, 8'h00);
    feat(adce_pkg::SF_LA_OFF, 8'h00, 8'h00);
    wreg(adce_pkg::A_CTRL, 16'h0004);
    wreg(adce_pkg::A_CTRL, 16'h0000);
    check("kept", 16'({xfer_mode, look_ahead, keep_settings, sec_frozen}),
          16'h0113);
    feat(adce_pkg::SF_POR_ON, 8'h00, 8'h00);
    feat(adce_pkg::SF_LA_ON, 8'h00, 8'h00);
    check("keep off", 16'({keep_settings, look_ahead}), 16'h0001);
    protect_flags <= 5'b10101;
    rreg(adce_pkg::A_PROT);
    check("protect", v, 16'ha100);
    $display("features finished");
  endtask : t_feat
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize
  initial begin
    {rst_n, wr, rd, dma_rd, slow, addr, wdata, protect_flags} = '0;
    err_lba = 28'h0ff_ffff;
    errors = 0;
    total_checks = 0;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    #1 check("reset", 16'({xfer_mode, look_ahead, idle_mode, sec_frozen}), 16'h0004);
    foreach (pio_ops[i]) t_pio(pio_ops[i]);
    t_dma(8'hc8);
    t_dma(8'hc9);
    t_dma(8'h25);
    t_verify();
    t_cmds();
    t_feat();
    summarize();
  end
  initial begin
    #1_000_000;
    errors++;
    summarize();
  end
endmodule : adce_engine_bench
